// *** rtl/erase_pkg.sv ***
// Constants and types shared by the erase control block
package erase_pkg;
    localparam logic [7:0] OP_SECTOR = 8'h20;
    localparam logic [7:0] OP_BLK32 = 8'h52;
    localparam logic [7:0] OP_BLK64 = 8'hd8;
    localparam logic [7:0] OP_CHIP_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_B = 8'h60;
    localparam int CLK_MHZ = 100;
    localparam int SECTOR_ERASE_TIME_US = 100000;
    localparam int BLOCK32_ERASE_TIME_US = 300000;
    localparam int BLOCK64_ERASE_TIME_US = 500000;
    localparam int CHIP_ERASE_TIME_US = 8000000;
    localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
    localparam int BLOCK32_ERASE_CYC = BLOCK32_ERASE_TIME_US * CLK_MHZ;
    localparam int BLOCK64_ERASE_CYC = BLOCK64_ERASE_TIME_US * CLK_MHZ;
    localparam int CHIP_ERASE_CYC = CHIP_ERASE_TIME_US * CLK_MHZ;
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_ADDR_CMD = 6'h20;
    localparam logic [5:0] BITS_SAT = 6'h21;
    localparam int SECTOR_LOG2 = 12;
    localparam int BLK32_LOG2 = 15;
    localparam int BLK64_LOG2 = 16;
    localparam int MEM_LOG2_DEF = 20;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [2:0] PROTECT_NONE = 3'h0;
    typedef enum logic [1:0] {
        KIND_SECTOR = 2'h0,
        KIND_BLK32 = 2'h1,
        KIND_BLK64 = 2'h2,
        KIND_CHIP = 2'h3
    } erase_kind_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERASE = 2'b01,
        ST_FINISH = 2'b11
    } erase_state_type;
endpackage : erase_pkg

// *** rtl/erase_timer.sv ***
// Self-timed erase cycle counter
`timescale 1ns/1ns
module erase_timer (
    input wire logic clk_i,
    input wire logic srst_i,
    erase_timer_if.timer tmr
);
    logic [31:0] count_q, count_d;
    logic running_q, running_d;
    logic done_q, done_d;

    always_comb begin
        count_d = count_q;
        running_d = running_q;
        done_d = 1'b0;
        if (tmr.start) begin
            count_d = tmr.cycles - 32'h1;
            running_d = 1'b1;
        end else if (running_q) begin
            if (count_q == 32'h0) begin
                running_d = 1'b0;
                done_d = 1'b1;
            end else begin
                count_d = count_q - 32'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count_q <= 32'h0;
            running_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            count_q <= count_d;
            running_q <= running_d;
            done_q <= done_d;
        end
    end

    assign tmr.done = done_q;
endmodule : erase_timer

// *** rtl/erase_timer_if.sv ***
// Link between the erase sequencer and its cycle timer
`timescale 1ns/1ns
interface erase_timer_if;
    logic start;
    logic [31:0] cycles;
    logic done;
    modport ctrl (output start, output cycles, input done);
    modport timer (input start, input cycles, output done);
endinterface : erase_timer_if

// *** rtl/flash_erase_ctrl.sv ***
// Erase instruction decode, protection gating and erase cycle sequencing
`timescale 1ns/1ns
module flash_erase_ctrl import erase_pkg::*; #(
    parameter int unsigned SECTOR_CYC = SECTOR_ERASE_CYC,
    parameter int unsigned BLOCK32_CYC = BLOCK32_ERASE_CYC,
    parameter int unsigned BLOCK64_CYC = BLOCK64_ERASE_CYC,
    parameter int unsigned CHIP_CYC = CHIP_ERASE_CYC,
    parameter int MEM_LOG2 = MEM_LOG2_DEF
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic SCK_I,
    input wire logic CS_N_I,
    input wire logic SI_I,
    input wire logic WRITE_ENABLE_SET_I,
    input wire logic [2:0] PROTECT_RANGE_I,
    output logic WRITE_IN_PROGRESS_O,
    output logic WRITE_ENABLE_LATCH_O,
    output logic ERASE_START_O,
    output logic [1:0] ERASE_KIND_O,
    output logic [23:0] ERASE_ADDR_O,
    output logic [7:0] ERASE_FILL_O
);
    if (MEM_LOG2 < BLK64_LOG2 || MEM_LOG2 > 24) begin : g_bad_mem
        $error("MEM_LOG2 out of range");
    end
    if (SECTOR_CYC < 1 || BLOCK32_CYC < 1 || BLOCK64_CYC < 1 || CHIP_CYC < 1) begin : g_bad_cyc
        $error("erase cycle counts must be at least one");
    end

    // Low bits that address bytes inside one erase unit
    function automatic logic [23:0] unit_mask(erase_kind_type k);
        unique case (k)
            KIND_SECTOR: unit_mask = 24'((32'h1 << SECTOR_LOG2) - 1);
            KIND_BLK32: unit_mask = 24'((32'h1 << BLK32_LOG2) - 1);
            KIND_BLK64: unit_mask = 24'((32'h1 << BLK64_LOG2) - 1);
            KIND_CHIP: unit_mask = 24'((32'h1 << MEM_LOG2) - 1);
        endcase
    endfunction : unit_mask

    // Protection grows down from the top of the array from 64KB, doubling with each range step
    function automatic logic prot_hit(logic [23:0] a, erase_kind_type k, logic [2:0] bp);
        logic [31:0] prot_size;
        logic [31:0] top;
        prot_hit = 1'b0;
        prot_size = 32'h1 << (BLK64_LOG2 + int'(bp) - 1);
        top = 32'(a | unit_mask(k)) & ((32'h1 << MEM_LOG2) - 32'h1);
        if (bp != PROTECT_NONE) begin
            if (k == KIND_CHIP || prot_size >= (32'h1 << MEM_LOG2)) begin
                prot_hit = 1'b1;
            end else begin
                prot_hit = top >= (32'h1 << MEM_LOG2) - prot_size;
            end
        end
    endfunction : prot_hit

    erase_timer_if tmr ();
    erase_timer u_timer (.clk_i(CLK_I), .srst_i(SRST_I), .tmr(tmr));

    // Link pins cross into the core clock through two flops before use
    logic [2:0] sck_q, sck_d;
    logic [2:0] cs_q, cs_d;
    logic [1:0] si_q, si_d;
    logic sck_rise, cs_rise, cs_low;

    always_comb begin
        sck_d = {sck_q[1:0], SCK_I};
        cs_d = {cs_q[1:0], CS_N_I};
        si_d = {si_q[0], SI_I};
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            sck_q <= 3'h0;
            cs_q <= 3'h7;
            si_q <= 2'h0;
        end else begin
            sck_q <= sck_d;
            cs_q <= cs_d;
            si_q <= si_d;
        end
    end

    assign sck_rise = sck_q[1] & ~sck_q[2];
    assign cs_rise = cs_q[1] & ~cs_q[2];
    assign cs_low = ~cs_q[1];

    // Frame shifter; bit count saturates so overlong frames never match
    logic [31:0] shift_q, shift_d;
    logic [5:0] bits_q, bits_d;

    always_comb begin
        shift_d = shift_q;
        bits_d = bits_q;
        if (!cs_low) begin
            bits_d = 6'h0;
        end else if (sck_rise) begin
            shift_d = {shift_q[30:0], si_q[1]};
            if (bits_q != BITS_SAT) begin
                bits_d = bits_q + 6'h1;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            shift_q <= 32'h0;
            bits_q <= 6'h0;
        end else begin
            shift_q <= shift_d;
            bits_q <= bits_d;
        end
    end

    // Decode at the closing select edge only
    logic cmd_ok;
    erase_kind_type cmd_kind;
    logic [23:0] cmd_addr;
    logic go;

    always_comb begin
        cmd_ok = 1'b0;
        cmd_kind = KIND_CHIP;
        cmd_addr = shift_q[23:0];
        if (bits_q == BITS_OPCODE && (shift_q[7:0] == OP_CHIP_A || shift_q[7:0] == OP_CHIP_B)) begin
            cmd_ok = 1'b1;
            cmd_addr = 24'h0;
        end else if (bits_q == BITS_ADDR_CMD) begin
            cmd_ok = 1'b1;
            unique case (shift_q[31:24])
                OP_SECTOR: cmd_kind = KIND_SECTOR;
                OP_BLK32: cmd_kind = KIND_BLK32;
                OP_BLK64: cmd_kind = KIND_BLK64;
                default: cmd_ok = 1'b0;
            endcase
        end
    end

    erase_state_type state_q, state_d;
    erase_kind_type kind_q, kind_d;
    logic [23:0] addr_q, addr_d;
    logic write_enable_latch_q, write_enable_latch_d;
    logic write_in_progress_q, write_in_progress_d;
    logic start_q, start_d;
    logic [31:0] cyc_sel;

    // Busy device ignores new erase frames until the cycle ends
    assign go = cs_rise && cmd_ok && state_q == ST_IDLE && write_enable_latch_q
        && !prot_hit(cmd_addr, cmd_kind, PROTECT_RANGE_I);

    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        addr_d = addr_q;
        write_enable_latch_d = write_enable_latch_q;
        start_d = 1'b0;
        cyc_sel = CHIP_CYC;
        unique case (cmd_kind)
            KIND_SECTOR: cyc_sel = SECTOR_CYC;
            KIND_BLK32: cyc_sel = BLOCK32_CYC;
            KIND_BLK64: cyc_sel = BLOCK64_CYC;
            KIND_CHIP: cyc_sel = CHIP_CYC;
        endcase
        unique case (state_q)
            ST_IDLE: begin
                if (go) begin
                    state_d = ST_ERASE;
                    start_d = 1'b1;
                    kind_d = cmd_kind;
                    addr_d = cmd_addr & ~unit_mask(cmd_kind);
                    // Clearing at start is the earliest safe point
                    if (cmd_kind != KIND_CHIP) begin
                        write_enable_latch_d = 1'b0;
                    end
                end
            end
            ST_ERASE: begin
                if (tmr.done) begin
                    state_d = ST_FINISH;
                end
            end
            ST_FINISH: begin
                state_d = ST_IDLE;
                if (kind_q == KIND_CHIP) begin
                    write_enable_latch_d = 1'b0;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // Write enable set wins over any clear in the same cycle
        if (WRITE_ENABLE_SET_I) begin
            write_enable_latch_d = 1'b1;
        end
        write_in_progress_d = state_d != ST_IDLE;
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state_q <= ST_IDLE;
            kind_q <= KIND_SECTOR;
            addr_q <= 24'h0;
            write_enable_latch_q <= 1'b0;
            write_in_progress_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            addr_q <= addr_d;
            write_enable_latch_q <= write_enable_latch_d;
            write_in_progress_q <= write_in_progress_d;
            start_q <= start_d;
        end
    end

    assign tmr.start = start_d;
    assign tmr.cycles = cyc_sel;

    assign WRITE_IN_PROGRESS_O = write_in_progress_q;
    assign WRITE_ENABLE_LATCH_O = write_enable_latch_q;
    assign ERASE_START_O = start_q;
    assign ERASE_KIND_O = kind_q;
    assign ERASE_ADDR_O = addr_q;
    // Fill value is fixed, so the array side needs no per-kind data path
    assign ERASE_FILL_O = ERASED_BYTE;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    sequence s_valid_close;
        cs_rise && cmd_ok && state_q == ST_IDLE && write_enable_latch_q;
    endsequence
    sequence s_cycle_end;
        state_q == ST_FINISH ##1 state_q == ST_IDLE;
    endsequence

    a_start_on_rise: assert property (
        s_valid_close ##0 !prot_hit(cmd_addr, cmd_kind, PROTECT_RANGE_I) |=> start_q
            && state_q == ST_ERASE)
        else $error("valid erase frame did not start a cycle");
    a_start_needs_latch: assert property (
        $rose(state_q == ST_ERASE) |-> $past(write_enable_latch_q) && $past(cs_rise))
        else $error("erase started without write enable");
    a_flag_busy: assert property (
        state_q == ST_ERASE |=> WRITE_IN_PROGRESS_O)
        else $error("flag low during erase");
    a_flag_clears_idle: assert property (
        s_cycle_end |-> !WRITE_IN_PROGRESS_O)
        else $error("flag still high after cycle end");
    a_latch_addr_clear: assert property (
        start_q && kind_q != KIND_CHIP && !$past(WRITE_ENABLE_SET_I) |-> !write_enable_latch_q)
        else $error("latch not cleared at addressed erase");
    a_latch_chip_clear: assert property (
        state_q == ST_FINISH && kind_q == KIND_CHIP && !WRITE_ENABLE_SET_I
            |=> !write_enable_latch_q)
        else $error("latch not cleared after chip erase");
    // Frame length checks read the count still held at the closing edge
    a_addr_frame_bits: assert property (
        start_q && kind_q != KIND_CHIP |-> $past(bits_q) == BITS_ADDR_CMD)
        else $error("addressed erase started from a wrong bit count");
    a_chip_frame_bits: assert property (
        start_q && kind_q == KIND_CHIP |-> $past(bits_q) == BITS_OPCODE)
        else $error("chip erase started from a wrong bit count");
    a_start_kind: assert property (
        start_q |-> ERASE_KIND_O == $past(cmd_kind))
        else $error("erase kind differs from the decoded opcode");
    a_busy_refuse: assert property (
        cs_rise && state_q != ST_IDLE |=> !start_q)
        else $error("frame accepted while a cycle runs");
    a_refused_latch: assert property (
        cs_rise && !cmd_ok && state_q == ST_IDLE && !WRITE_ENABLE_SET_I
            |=> $stable(WRITE_ENABLE_LATCH_O))
        else $error("refused frame changed the latch");
    a_sector_align: assert property (
        start_q |-> (ERASE_ADDR_O & unit_mask(erase_kind_type'(ERASE_KIND_O))) == 24'h0)
        else $error("erase address not aligned to its unit");
    a_protect_block: assert property (
        s_valid_close ##0 prot_hit(cmd_addr, cmd_kind, PROTECT_RANGE_I) |=> !start_q)
        else $error("protected region erase started");
    a_chip_protect: assert property (
        start_q && kind_q == KIND_CHIP |-> $past(PROTECT_RANGE_I) == PROTECT_NONE)
        else $error("chip erase under protection");
    a_timed_cycle: assert property (
        start_q |-> WRITE_IN_PROGRESS_O [*3])
        else $error("cycle shorter than the least count");
endmodule : flash_erase_ctrl

// *** verif/spi_flash_erase_control_tb.sv ***
// Self-checking bench for the erase control block with a reference model
`timescale 1ns/1ns
module spi_flash_erase_control_tb;
    import erase_pkg::*;
    localparam int SEC_N = 20;
    localparam int B32_N = 30;
    localparam int B64_N = 40;
    localparam int CHIP_N = 50;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic latch_set = 1'b0;
    logic [2:0] bp = 3'h0;
    logic sck, cs_n, si, busy, latch, start;
    logic [1:0] kind;
    logic [23:0] addr;
    logic [7:0] fill;
    logic [7:0] ops [5] = '{OP_SECTOR, OP_BLK32, OP_BLK64, OP_CHIP_A, OP_CHIP_B};
    int n_errors = 0;
    int n_compared = 0;
    bit latch_m = 1'b0;
    int r, j;
    spi_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si));
    flash_erase_ctrl #(.SECTOR_CYC(SEC_N), .BLOCK32_CYC(B32_N), .BLOCK64_CYC(B64_N),
        .CHIP_CYC(CHIP_N), .MEM_LOG2(20)) dut (.CLK_I(clk), .SRST_I(srst), .SCK_I(sck),
        .CS_N_I(cs_n), .SI_I(si), .WRITE_ENABLE_SET_I(latch_set), .PROTECT_RANGE_I(bp),
        .WRITE_IN_PROGRESS_O(busy), .WRITE_ENABLE_LATCH_O(latch), .ERASE_START_O(start),
        .ERASE_KIND_O(kind), .ERASE_ADDR_O(addr), .ERASE_FILL_O(fill));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    task automatic set_latch;
        @(negedge clk) latch_set = 1'b1;
        @(negedge clk) latch_set = 1'b0;
        latch_m = 1'b1;
    endtask : set_latch
    // Reference decision, then one frame and the device's answer
    task automatic erase(input logic [7:0] op, input logic [23:0] a, input int nbits);
        int unit, cyc, k, lo, b, cnt;
        bit ok, seen;
        ok = 1'b1;
        k = 0;
        unit = 4096;
        cyc = SEC_N;
        case (op)
            OP_BLK32: begin k = 1; unit = 32768; cyc = B32_N; end
            OP_BLK64: begin k = 2; unit = 65536; cyc = B64_N; end
            OP_CHIP_A, OP_CHIP_B: begin k = 3; unit = 1 << 20; cyc = CHIP_N; end
            OP_SECTOR: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        if (nbits != ((k == 3) ? 8 : 32) || !latch_m) ok = 1'b0;
        // Top 64KB << (range-1) is locked; the whole array from range 5 up
        lo = (bp == 0) ? (1 << 20) : (bp >= 5) ? 0 : (1 << 20) - (65536 << (bp - 1));
        b = int'(a[19:0]) & ~(unit - 1);
        if (b + unit > lo) ok = 1'b0;
        host.send({op, a, 8'h00} >> (40 - nbits), nbits);
        seen = 1'b0;
        for (int i = 0; i < 12 && !seen; i++) begin
            @(negedge clk);
            seen = (start === 1'b1);
        end
        chk(seen, ok);
        if (seen) begin
            chk(kind, k);
            chk(addr, (k == 3) ? 24'h0 : a & ~(unit - 1));
            chk(fill, ERASED_BYTE);
            if (k != 3) chk(latch, 1'b0);
            cnt = 0;
            while (busy === 1'b1 && cnt < 1000) begin
                @(negedge clk);
                cnt++;
            end
            if (cnt == 1000) begin
                n_errors++;
                give_verdict();
            end
            chk(cnt >= cyc && cnt <= cyc + 3, 1'b1);
            latch_m = 1'b0;
            chk(latch, 1'b0);
        end else begin
            chk(busy, 1'b0);
            chk(latch, latch_m);
        end
    endtask : erase
    initial begin
        r = $urandom(32627);
        repeat (3) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        chk({busy, latch, kind, fill}, {4'h0, ERASED_BYTE});
        chk({start, addr}, 25'h0);
        // Every erase code, unprotected, random addresses
        for (int i = 0; i < 5; i++) begin
            set_latch();
            erase(ops[i], 24'($urandom), (i > 2) ? 8 : 32);
        end
        // Latch clear, wrong bit counts and an unknown code are all refused
        erase(OP_SECTOR, 24'h001234, 32);
        set_latch();
        erase(OP_SECTOR, 24'h002345, 31);
        erase(OP_BLK64, 24'h030000, 33);
        erase(OP_CHIP_A, 24'h0, 9);
        erase(8'h03, 24'h0, 32);
        // Lowest protect range: top 64KB locked, just below it open
        @(negedge clk) bp = 3'h1;
        erase(OP_SECTOR, 24'h0ff123, 32);
        erase(OP_CHIP_B, 24'h0, 8);
        erase(OP_BLK32, 24'h0effff, 32);
        set_latch();
        erase(OP_BLK64, 24'hfeffff, 32);
        // Random mix; host waits for the flag to drop before each frame
        for (int i = 0; i < 12; i++) begin
            j = $urandom_range(0, 5);
            @(negedge clk) bp = 3'($urandom_range(0, 7));
            if ($urandom_range(0, 1) == 1) set_latch();
            erase((j == 5) ? 8'h9f : ops[j], 24'($urandom), (j == 3 || j == 4) ? 8 : 32);
        end
        give_verdict();
    end
endmodule : spi_flash_erase_control_tb

// *** verif/spi_host_model.sv ***
// Behavioural serial host that frames erase instructions
`timescale 1ns/1ns
module spi_host_model (
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o
);
    localparam int HALF_NS = 40;
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    // Serial clock stands still outside frames; bits go out MSB first
    task automatic send(input logic [39:0] bits, input int n);
        #3 cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si_o = bits[i];
            #HALF_NS sck_o = 1'b1;
            #HALF_NS sck_o = 1'b0;
        end
        #HALF_NS cs_n_o = 1'b1;
        // Released data line must not keep looking valid
        si_o = ~si_o;
    endtask : send
endmodule : spi_host_model
